// >>> sim/complementary_output_shutdown_steering_tb_top.sv
// bench: registers, falling sources, shutdown, steering and dead-band
// assumes cosd_top and the source model
`timescale 1ns/1ps
module complementary_output_shutdown_steering_tb_top;
reg clk_i, nrst_i, wr_i, rd_i, rreq, slow;
reg [3:0] addr_i, wset, sset, pol;
reg [7:0] wdata_i, fset, v, st;
reg [7:0] mdl [0:15];
reg [31:0] seed;
wire [7:0] rdata_o, fsrc;
wire [3:0] sdsrc, wave, out_o, oe;
wire rev, tick, fev, prim;
integer error_cnt, tests_run, cyc, i, n;
cosd_src_model i_src (.clk_i(clk_i), .nrst_i(nrst_i), .fall_set_i(fset), .sd_set_i(sset),
   .wave_set_i(wset), .rise_req_i(rreq), .slow_i(slow), .fall_src_o(fsrc), .sd_src_o(sdsrc),
   .wave_o(wave), .rise_event_o(rev), .chain_tick_o(tick));
cosd_top i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fall_src_i(fsrc), .sd_src_i(sdsrc),
   .rise_event_i(rev), .chain_tick_i(tick), .wave_i(wave), .out_o(out_o), .out_oe_o(oe),
   .fall_event_o(fev), .primary_o(prim));
// ****
// helpers
// ****
function [31:0] rnd();
   seed = seed ^ (seed << 13);
   seed = seed ^ (seed >> 17);
   seed = seed ^ (seed << 5);
   rnd = seed;
endfunction
function [7:0] msk(input [3:0] a);
   msk = a[3] ? 8'h00 : a == 4'h2 ? 8'hfc : a == 4'h3 ? 8'h0f : a == 4'h7 ? 8'h8f :
      a > 4'h4 ? 8'h3f : 8'hff;
endfunction
task chk(input [79:0] nm, input [7:0] e, input [7:0] s);
   begin
      tests_run = tests_run + 1;
      if (s !== e) begin
         error_cnt = error_cnt + 1;
         $display("mismatch %0s exp %h got %h", nm, e, s);
      end
   end
endtask
task wr(input [3:0] a, input [7:0] d);
   begin
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   end
endtask
task rd(input [3:0] a);
   begin
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      v = rdata_o;
   end
endtask
task hold(input integer k);
   begin
      repeat (k) @(posedge clk_i);
      #1;
   end
endtask
// count cycles until primary (w=1, after a rising pulse) or falling event (w=0)
task wt(input w, input [7:0] f);
   begin
      @(posedge clk_i);
      rreq <= w;
      fset <= f;
      @(posedge clk_i);
      rreq <= 1'b0;
      #1;
      n = 1;
      while ((w ? prim : fev) !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         #1;
         n = n + 1;
      end
   end
endtask
task conclude;
   begin
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
endtask
// clock and hang guard
initial begin
   clk_i = 1'b0;
   forever #50 clk_i = ~clk_i;
end
always @(posedge clk_i) begin
   cyc = cyc + 1;
   if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      conclude;
   end
end
// ****
// main sequence
// ****
initial begin
   {nrst_i, wr_i, rd_i, rreq, slow, addr_i, wdata_i, wset} = 0;
   fset = 8'hff;
   sset = 4'hf;
   seed = 32'h51928b0b;
   error_cnt = 0;
   tests_run = 0;
   cyc = 0;
   repeat (20) @(posedge clk_i);
   nrst_i <= 1'b1;
   for (i = 0; i < 16; i = i + 1) begin
      rd(i[3:0]);
      chk("reset", 8'h00, v);
      mdl[i] = rnd() & (i == 2 ? 8'h7c : 8'hff);
      wr(i[3:0], mdl[i]);
      rd(i[3:0]);
      chk("readback", mdl[i] & msk(i[3:0]), v);
   end
   for (i = 0; i < 8; i = i + 1)
      wr(i[3:0], 8'h00);
   for (i = 0; i < 8; i = i + 1) begin
      wr(4'h1, 8'h01 << i);
      fset <= 8'h01 << i;
      hold(4);
      chk("fall off", 8'h00, fev);
      fset <= 8'h00;
      hold(3);
      chk("fall lvl", 8'h01, fev);
      fset <= 8'hff;
   end
   wr(4'h0, 8'h01);
   for (i = 0; i < 2; i = i + 1) begin
      wr(4'h6, i ? 8'h45 : 8'h00);
      wr(4'h1, 8'h01);
      wt(1'b0, 8'hfe);
      chk("edge dly", 8'h01, n >= i * 5 + 2 && n <= i * 5 + 4);
      hold(1);
      chk("edge pulse", 8'h00, fev);
      fset <= 8'hff;
      wr(4'h1, 8'h00);
   end
   wr(4'h0, 8'h00);
   for (i = 0; i < 4; i = i + 1) begin
      v = rnd();
      st = rnd();
      pol = v[3:0];
      wr(4'h7, {4'h0, pol});
      wr(4'h4, st);
      wset <= v[7:4];
      hold(3);
      chk("steer", {4'hf, st[3:0] & (v[7:4] ^ pol) | ~st[3:0] & st[7:4]}, {oe, out_o});
   end
   wr(4'h4, 8'h60);
   for (i = 0; i < 4; i = i + 1) begin
      wr(4'h3, 8'h01 << i);
      wr(4'h2, {2'b01, i[1:0], i[1:0], 2'b00});
      sset <= ~(4'h1 << i);
      hold(4);
      rd(4'h2);
      chk("status", {2'b11, i[1:0], i[1:0], 2'b00}, v);
      chk("override", i == 1 ? 8'h00 : {4'hf, i == 3 ? 4'hf : i == 0 ? pol : 4'h0},
         {oe, i == 1 ? 4'h0 : out_o});
      sset <= 4'hf;
      hold(3);
      rd(4'h2);
      chk("restart", {2'b01, i[1:0], i[1:0], 2'b00}, v);
      wt(1'b1, 8'hff);
      hold(3);
      chk("resume", 8'hf6, {oe, out_o});
   end
   wr(4'h2, 8'ha8);
   hold(3);
   chk("sw set", 8'hf0, {oe, out_o});
   wr(4'h2, 8'h28);
   wt(1'b1, 8'hff);
   hold(3);
   chk("sw clr", 8'hf6, {oe, out_o});
   wr(4'h5, 8'hc3);
   for (i = 0; i < 2; i = i + 1) begin
      wr(4'h7, {i[0], 7'h00});
      slow <= i[0];
      wr(4'h1, 8'h01);
      wt(1'b0, 8'hfe);
      fset <= 8'hff;
      wr(4'h1, 8'h00);
      hold(2);
      chk("prim low", 8'h00, prim);
      wt(1'b1, 8'hff);
      chk("deadband", 8'h01, i ? n >= 10 && n <= 20 : n >= 6 && n <= 8);
   end
   conclude;
end
endmodule

// >>> sim/cosd_chk_assertions.sv
// port checker for the shutdown/steering block
// assumes one clock domain and the active-low asynchronous reset
`timescale 1ns/1ps
module cosd_chk #(
   parameter NSRC = 8,
   parameter NSD = 4
) (
   input wire clk_i,
   input wire nrst_i,
   input wire [3:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire [NSRC-1:0] fall_src_i,
   input wire [NSD-1:0] sd_src_i,
   input wire [3:0] out_o,
   input wire [3:0] out_oe_o,
   input wire fall_event_o
);
reg [NSRC-1:0] fe;
reg [NSRC-1:0] fm;
reg [NSD-1:0] s1;
reg [3:0] ovr;
// shadow of the registers that the properties lean on
always @(posedge clk_i or negedge nrst_i) begin
   if (!nrst_i) begin
      fe <= {NSRC{1'b0}};
      fm <= {NSRC{1'b0}};
      s1 <= {NSD{1'b0}};
      ovr <= 4'h0;
   end else if (wr_i) begin
      fe <= (addr_i == 4'h1) ? wdata_i[NSRC-1:0] : fe;
      fm <= (addr_i == 4'h0) ? wdata_i[NSRC-1:0] : fm;
      s1 <= (addr_i == 4'h3) ? wdata_i[NSD-1:0] : s1;
      ovr <= (addr_i == 4'h2) ? wdata_i[5:2] : ovr;
   end
end
default clocking @(posedge clk_i); endclocking
default disable iff (!nrst_i);
lvl_fall_a:
   assert property (|(fe & ~fm & ~fall_src_i) |=> fall_event_o) else $error("level fall missed");
off_fall_a:
   assert property (fe == 0 [*8] |=> !fall_event_o) else $error("disabled source fired");
sd_low_a:
   assert property ((|(s1 & ~sd_src_i) && ovr == 4'ha && !wr_i) ##1 !wr_i
      |=> ##1 out_o == 4'h0 && out_oe_o == 4'hf) else $error("low override missing");
sd_tri_a:
   assert property ((|(s1 & ~sd_src_i) && ovr == 4'h5 && !wr_i) ##1 !wr_i
      |=> ##1 out_oe_o == 4'h0) else $error("tri-state override missing");
sd_high_a:
   assert property ((|(s1 & ~sd_src_i) && ovr == 4'hf && !wr_i) ##1 !wr_i
      |=> ##1 out_o == 4'hf && out_oe_o == 4'hf) else $error("high override missing");
gap_rd_a:
   assert property (rd_i && addr_i[3] |=> rdata_o == 8'h00) else $error("unmapped read not zero");
sd0_rd_a:
   assert property (rd_i && addr_i == 4'h2 |=> rdata_o[1:0] == 2'b00) else $error("sd0 low bits");
sd1_rd_a:
   assert property ((wr_i && addr_i == 4'h3) ##2 (rd_i && addr_i == 4'h3)
      |=> rdata_o == ($past(wdata_i, 3) & 8'h0f)) else $error("sd1 read back");
endmodule
bind cosd_top cosd_chk #(.NSRC(NSRC), .NSD(NSD)) i_chk (.clk_i(clk_i), .nrst_i(nrst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .fall_src_i(fall_src_i), .sd_src_i(sd_src_i), .out_o(out_o), .out_oe_o(out_oe_o),
   .fall_event_o(fall_event_o));

// >>> sim/cosd_src_model.sv
// event source and far-side model for the shutdown/steering block
// assumes the bench drives the wanted levels; all outputs change on clk_i
`timescale 1ns/1ps
module cosd_src_model (
   input wire clk_i,
   input wire nrst_i,
   input wire [7:0] fall_set_i,
   input wire [3:0] sd_set_i,
   input wire [3:0] wave_set_i,
   input wire rise_req_i,
   input wire slow_i,
   output reg [7:0] fall_src_o,
   output reg [3:0] sd_src_o,
   output reg [3:0] wave_o,
   output reg rise_event_o,
   output reg chain_tick_o
);
reg [1:0] div;
// sources follow the requests one clock later; chain ticks slow down on demand
always @(posedge clk_i or negedge nrst_i) begin
   if (!nrst_i) begin
      fall_src_o <= 8'hff;
      sd_src_o <= 4'hf;
      wave_o <= 4'h0;
      rise_event_o <= 1'b0;
      chain_tick_o <= 1'b0;
      div <= 2'h0;
   end else begin
      fall_src_o <= fall_set_i;
      sd_src_o <= sd_set_i;
      wave_o <= wave_set_i;
      rise_event_o <= rise_req_i;
      div <= div + 2'h1;
      chain_tick_o <= slow_i ? (div == 2'h3) : 1'b1;
   end
end
endmodule

// >>> src/cosd_defines.vh
// register offsets, field positions and reset values for the shutdown/steering block
// assumes an 8-bit register port with index addressing
`ifndef COSD_DEFINES_VH
`define COSD_DEFINES_VH

// ***************************************
// register indices
// ***************************************
`define COSD_ADDR_FMODE 4'h0
`define COSD_ADDR_FENA 4'h1
`define COSD_ADDR_SD0 4'h2
`define COSD_ADDR_SD1 4'h3
`define COSD_ADDR_STEER 4'h4
`define COSD_ADDR_RDB 4'h5
`define COSD_ADDR_PHF 4'h6
`define COSD_ADDR_CFG 4'h7

// ***************************************
// field positions
// ***************************************
`define COSD_SD0_STATUS 7
`define COSD_SD0_ARST 6
`define COSD_SD0_BD_HI 5
`define COSD_SD0_BD_LO 4
`define COSD_SD0_AC_HI 3
`define COSD_SD0_AC_LO 2
`define COSD_CFG_RDBS 7

// ***************************************
// masks and reset values
// ***************************************
`define COSD_SD0_MASK 8'hfc
`define COSD_SD1_MASK 8'h0f
`define COSD_CNT6_MASK 8'h3f
`define COSD_CFG_MASK 8'h8f
`define COSD_RST_8 8'h00
`define COSD_RST_6 6'h00

// override level codes
`define COSD_OVR_HIGH 2'h3
`define COSD_OVR_LOW 2'h2
`define COSD_OVR_TRI 2'h1
`define COSD_OVR_INACT 2'h0

`endif

// >>> src/cosd_delay.v
// one 6-bit down counter used for the dead-band and phase delays
// assumes load and tick are synchronous to clk_i
`timescale 1ns/1ps
module cosd_delay #(
   parameter WIDTH = 6
) (
   input wire clk_i,
   input wire nrst_i,
   input wire load_i,
   input wire [WIDTH-1:0] value_i,
   input wire tick_i,
   output reg busy_o,
   output wire done_o
);
   reg [WIDTH-1:0] count;
   // done on a tick while busy with the count at zero
   assign done_o = busy_o && (count == {WIDTH{1'b0}}) && tick_i;

   // counts ticks down from the loaded value
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count <= {WIDTH{1'b0}};
         busy_o <= 1'b0;
      end else if (load_i) begin
         count <= value_i;
         busy_o <= 1'b1;
      end else if (done_o) begin
         busy_o <= 1'b0;
      end else if (busy_o && tick_i) begin
         count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
endmodule

// >>> src/cosd_top.v
// falling-event source selection, auto-shutdown, steering and rising dead-band
// assumes event sources, waveforms and chain ticks are synchronous to clk_i
//
// Summary of operation
// - enabled edge source falls after phase delay
// - enabled level source low falls at once
// - disabled falling source is ignored entirely
// - mode bits pick edge or level detection per source
// - status bit reads one while shut down
// - bit six enables automatic restart
// - pair b/d forced by override code
// - pair a/c forced by override code
// - any enabled low shutdown source shuts down
// - static levels held per output
// - steering picks waveform or static level
// - six-bit rising dead-band in generator clocks
// - rising dead-band counts chain elements when selected
// - unimplemented bits ignore writes, read zero
// - falling phase delay is six-bit clock count
`timescale 1ns/1ps
`include "cosd_defines.vh"
module cosd_top #(
   parameter NSRC = 8,
   parameter NSD = 4
) (
   input wire clk_i,
   input wire nrst_i,
   input wire [3:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   input wire [NSRC-1:0] fall_src_i,
   input wire [NSD-1:0] sd_src_i,
   input wire rise_event_i,
   input wire chain_tick_i,
   input wire [3:0] wave_i,
   output reg [3:0] out_o,
   output reg [3:0] out_oe_o,
   output reg fall_event_o,
   output reg primary_o
);
   // ***************************************
   // registers
   // ***************************************
   reg [7:0] falling_mode_bits;
   reg [7:0] falling_source_enables;
   reg shutdown_status;
   reg auto_restart_enable;
   reg [1:0] override_level_pair_bd;
   reg [1:0] override_level_pair_ac;
   reg [3:0] shutdown_enables;
   reg [7:0] output_steering;
   reg [5:0] rising_deadband_value;
   reg [5:0] falling_phase_delay_value;
   reg rising_deadband_source_sel;
   reg [3:0] polarity;
   reg [NSRC-1:0] fall_src_q;
   reg shut_out;

   wire sd_wr = wr_i && (addr_i == `COSD_ADDR_SD0);
   wire [NSRC-1:0] edge_hit;
   wire [NSRC-1:0] level_hit;
   wire sd_request;
   wire sources_high;
   wire phf_done;
   wire phf_busy;
   wire rdb_done;
   wire rdb_busy;

   // ***************************************
   // register writes
   // ***************************************
   // falling source modes, enables and phase delay
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         falling_mode_bits <= `COSD_RST_8;
         falling_source_enables <= `COSD_RST_8;
         falling_phase_delay_value <= `COSD_RST_6;
      end else if (wr_i) begin
         case (addr_i)
            `COSD_ADDR_FMODE: falling_mode_bits <= wdata_i;
            `COSD_ADDR_FENA: falling_source_enables <= wdata_i;
            `COSD_ADDR_PHF: falling_phase_delay_value <= wdata_i[5:0];
            default: begin
            end
         endcase
      end
   end

   // shutdown controls; the status bit lives in its own process below
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         auto_restart_enable <= 1'b0;
         override_level_pair_bd <= 2'h0;
         override_level_pair_ac <= 2'h0;
         shutdown_enables <= 4'h0;
      end else if (wr_i) begin
         case (addr_i)
            `COSD_ADDR_SD0: begin
               auto_restart_enable <= wdata_i[`COSD_SD0_ARST];
               override_level_pair_bd <= wdata_i[`COSD_SD0_BD_HI:`COSD_SD0_BD_LO];
               override_level_pair_ac <= wdata_i[`COSD_SD0_AC_HI:`COSD_SD0_AC_LO];
            end
            `COSD_ADDR_SD1: shutdown_enables <= wdata_i[3:0];
            default: begin
            end
         endcase
      end
   end

   // steering, rising dead-band and polarity; unimplemented bits dropped
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         output_steering <= `COSD_RST_8;
         rising_deadband_value <= `COSD_RST_6;
         rising_deadband_source_sel <= 1'b0;
         polarity <= 4'h0;
      end else if (wr_i) begin
         case (addr_i)
            `COSD_ADDR_STEER: output_steering <= wdata_i;
            `COSD_ADDR_RDB: rising_deadband_value <= wdata_i[5:0];
            `COSD_ADDR_CFG: begin
               rising_deadband_source_sel <= wdata_i[`COSD_CFG_RDBS];
               polarity <= wdata_i[3:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ***************************************
   // register reads
   // ***************************************
   // read mux; unmapped indices and unimplemented bits give zero
   reg [7:0] next_rdata;
   always @* begin
      next_rdata = 8'h00;
      if (rd_i) begin
         case (addr_i)
            `COSD_ADDR_FMODE: next_rdata = falling_mode_bits;
            `COSD_ADDR_FENA: next_rdata = falling_source_enables;
            `COSD_ADDR_SD0: next_rdata = {shutdown_status, auto_restart_enable,
               override_level_pair_bd, override_level_pair_ac, 2'h0};
            `COSD_ADDR_SD1: next_rdata = {4'h0, shutdown_enables};
            `COSD_ADDR_STEER: next_rdata = output_steering;
            `COSD_ADDR_RDB: next_rdata = {2'h0, rising_deadband_value};
            `COSD_ADDR_PHF: next_rdata = {2'h0, falling_phase_delay_value};
            `COSD_ADDR_CFG: next_rdata = {rising_deadband_source_sel, 3'h0, polarity};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe, zero otherwise
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= next_rdata;
      end
   end

   // ***************************************
   // falling event selection
   // ***************************************
   // per-source edge and level detection
   genvar g;
   generate
      for (g = 0; g < NSRC; g = g + 1) begin : g_fsrc
         assign edge_hit[g] = falling_source_enables[g] && falling_mode_bits[g]
            && fall_src_q[g] && !fall_src_i[g];
         assign level_hit[g] = falling_source_enables[g] && !falling_mode_bits[g]
            && !fall_src_i[g];
      end
   endgenerate

   // previous source levels for edge detection
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fall_src_q <= {NSRC{1'b1}};
      end else begin
         fall_src_q <= fall_src_i;
      end
   end

   // phase delay on edge-mode falling events
   cosd_delay #(.WIDTH(6)) u_phf (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .load_i((|edge_hit) && !phf_busy),
      .value_i(falling_phase_delay_value),
      .tick_i(1'b1),
      .busy_o(phf_busy),
      .done_o(phf_done)
   );

   // falling event output: immediate level or delayed edge
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fall_event_o <= 1'b0;
      end else begin
         fall_event_o <= (|level_hit) || phf_done;
      end
   end

   // ***************************************
   // auto-shutdown
   // ***************************************
   assign sd_request = |(shutdown_enables & ~sd_src_i);
   assign sources_high = !sd_request;

   // status: hardware set wins over software clear
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         shutdown_status <= 1'b0;
      end else if (sd_request) begin
         shutdown_status <= 1'b1;
      end else if (sd_wr) begin
         shutdown_status <= wdata_i[`COSD_SD0_STATUS];
      end else if (auto_restart_enable && sources_high) begin
         shutdown_status <= 1'b0;
      end
   end

   // outputs leave shutdown only at a rising event
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         shut_out <= 1'b0;
      end else if (shutdown_status) begin
         shut_out <= 1'b1;
      end else if (rise_event_i) begin
         shut_out <= 1'b0;
      end
   end

   // ***************************************
   // rising dead-band
   // ***************************************
   // counts clocks or chain element ticks
   cosd_delay #(.WIDTH(6)) u_rdb (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .load_i(rise_event_i),
      .value_i(rising_deadband_value),
      .tick_i(rising_deadband_source_sel ? chain_tick_i : 1'b1),
      .busy_o(rdb_busy),
      .done_o(rdb_done)
   );

   // primary goes high when the dead-band expires, low on falling event
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         primary_o <= 1'b0;
      end else if (fall_event_o) begin
         primary_o <= 1'b0;
      end else if (rdb_done) begin
         primary_o <= 1'b1;
      end
   end

   // ***************************************
   // steering and override
   // ***************************************
   // next pin levels and enables, one slice per output a..d
   wire [3:0] next_out;
   wire [3:0] next_oe;
   genvar k;
   generate
      for (k = 0; k < 4; k = k + 1) begin : g_out
         // override code of this slice's pair
         wire [1:0] ovr_code;
         // waveform with this output's own polarity applied
         wire steered_wave;
         // static level from the upper nibble of the steering register
         wire static_level;
         // level and enable while shut down
         reg ovr_level;
         reg ovr_enable;
         if (k % 2 == 1) begin : g_bd
            assign ovr_code = override_level_pair_bd;
         end else begin : g_ac
            assign ovr_code = override_level_pair_ac;
         end
         assign steered_wave = wave_i[k] ^ polarity[k];
         assign static_level = output_steering[4 + k];

         // override decode; code zero gives the inactive level after polarity
         always @* begin
            case (ovr_code)
               `COSD_OVR_HIGH: begin
                  ovr_level = 1'b1;
                  ovr_enable = 1'b1;
               end
               `COSD_OVR_LOW: begin
                  ovr_level = 1'b0;
                  ovr_enable = 1'b1;
               end
               `COSD_OVR_TRI: begin
                  ovr_level = 1'b0; // pin released, level unused
                  ovr_enable = 1'b0;
               end
               default: begin
                  ovr_level = polarity[k];
                  ovr_enable = 1'b1;
               end
            endcase
         end

         // override beats steering; steering bit picks waveform or static level
         assign next_out[k] = shut_out ? ovr_level :
            (output_steering[k] ? steered_wave : static_level);
         assign next_oe[k] = shut_out ? ovr_enable : 1'b1;
      end
   endgenerate

   // registered pin levels and enables, so pins never glitch on a mux change
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out_o <= 4'h0;
         out_oe_o <= 4'h0;
      end else begin
         out_o <= next_out;
         out_oe_o <= next_oe;
      end
   end
endmodule
